// ---- design/mpp_top.sv ----
// pin multiplexing, direction and pull-up logic of ports 0, 1, 2, 3 and 7, and edge logic of port 0 bits 0 to 5
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mpp_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module mpp_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	// board pins
	input wire logic ext_reset_n,
	input wire logic vpp_high_in,
	input wire logic [7:0] p0_pin_in,
	output logic [7:0] p0_pin_out,
	output logic [7:0] p0_pin_oe,
	output logic [7:0] p0_pullup_en,
	input wire logic [7:0] p1_pin_in,
	output logic [7:0] p1_pin_out,
	output logic [7:0] p1_pin_oe,
	output logic [7:0] p1_pullup_en,
	input wire logic [2:0] p2_pin_in,
	output logic [2:0] p2_pin_out,
	output logic [2:0] p2_pin_oe,
	output logic [2:0] p2_pullup_en,
	input wire logic [7:0] p3_pin_in,
	output logic [7:0] p3_pin_out,
	output logic [7:0] p3_pin_oe,
	output logic [7:0] p3_pullup_en,
	input wire logic [2:0] p7_pin_in,
	output logic [2:0] p7_pin_out,
	output logic [2:0] p7_pin_oe,
	output logic [2:0] p7_pullup_en,
	// programming-mode pins
	input wire logic [16:0] prom_addr_in,
	input wire logic [7:0] prom_data_in,
	output logic [7:0] prom_data_out,
	output logic prom_data_oe,
	input wire logic prom_enable_n,
	input wire logic prom_read_n,
	input wire logic program_inhibit_in,
	// prom array side
	input wire logic [7:0] prom_rdata,
	output mpp_pkg::mpp_prom_req_t prom_req,
	output logic prom_mode,
	// peripherals
	input wire mpp_pkg::mpp_periph_in_t periph_in,
	output mpp_pkg::mpp_periph_out_t periph_out,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	localparam mpp_pkg::mpp_port_vec_t VALID_MASK =
		{`MPP_MASK_P7, `MPP_MASK_P3, `MPP_MASK_P2, `MPP_MASK_P1, `MPP_MASK_P0};
	localparam mpp_pkg::mpp_port_vec_t OUT_CAP =
		{`MPP_MASK_P7, `MPP_MASK_P3, `MPP_MASK_P2, `MPP_MASK_P1, `MPP_P0_OUT_MASK};
	localparam logic [4:0][2:0] PORT_NUM = {3'h7, 3'h3, 3'h2, 3'h1, 3'h0};

	function automatic logic [3:0] port_slot(input logic [2:0] num);
		logic [3:0] r;
		r = 4'h8;
		for (int k = 0; k < 5; k++) begin
			if (PORT_NUM[k] == num) begin
				r = {1'b0, 3'(k)};
			end
		end
		return r;
	endfunction : port_slot

	////////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [1:0] rst_vpp_s;
	logic int_rst;
	mpp_pkg::mpp_port_vec_t pin_s;
	logic [27:0] prom_s;
	logic prom_enable_n_s;
	logic prom_read_n_s;
	logic pgm_s;
	logic [16:0] prom_addr_s;
	logic [7:0] prom_data_s;

	mpp_sync #(.W(2)) u_sync_ctl (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({vpp_high_in, ~ext_reset_n}),
		.sync_out(rst_vpp_s)
	);

	mpp_sync #(.W(40)) u_sync_pins (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({5'h00, p7_pin_in, p3_pin_in, 5'h00, p2_pin_in, p1_pin_in, p0_pin_in}),
		.sync_out(pin_s)
	);

	mpp_sync #(.W(28)) u_sync_prom (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({prom_enable_n, prom_read_n, program_inhibit_in, prom_addr_in, prom_data_in}),
		.sync_out(prom_s)
	);

	assign {prom_enable_n_s, prom_read_n_s, pgm_s, prom_addr_s, prom_data_s} = prom_s;
	// reset pin enters inverted, so a synchroniser held in reset reads it as released
	assign int_rst = sys_rst | rst_vpp_s[0];

	////////////////////////////////////////////////////////////////////////////
	// programming mode
	logic prom_mode_q;
	logic pgm_prev_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prom_mode_q <= 1'b0;
		end else begin
			prom_mode_q <= rst_vpp_s[1] | rst_vpp_s[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pgm_prev_q <= 1'b0;
			prom_req <= '0;
			prom_data_out <= 8'h00;
			prom_data_oe <= 1'b0;
		end else begin
			pgm_prev_q <= pgm_s;
			prom_req.active <= prom_mode_q;
			prom_req.addr <= prom_addr_s;
			prom_req.wdata <= prom_data_s;
			// program pulse: falling program input while enabled and not reading
			prom_req.write_pulse <= prom_mode_q & ~prom_enable_n_s & prom_read_n_s &
				pgm_prev_q & ~pgm_s;
			prom_req.read_active <= prom_mode_q & ~prom_enable_n_s & ~prom_read_n_s & pgm_s;
			prom_data_oe <= prom_mode_q & ~prom_enable_n_s & ~prom_read_n_s & pgm_s;
			prom_data_out <= prom_rdata;
		end
	end

	assign prom_mode = prom_mode_q;

	////////////////////////////////////////////////////////////////////////////
	// registers
	mpp_pkg::mpp_port_vec_t latch_q;
	mpp_pkg::mpp_port_vec_t dir_q;
	mpp_pkg::mpp_port_vec_t ctrl_q;
	logic [7:0] pullup_option_low_q;
	logic [5:0] rise_q;
	logic [5:0] fall_q;
	logic [5:0] stat_q;
	logic [5:0] edge_pulse;
	logic [3:0] slot;
	logic wr_ok;

	assign slot = port_slot(reg_addr[2:0]);
	// software writes are locked out while the programmer owns the pins; reads still answer
	assign wr_ok = reg_wr & ~prom_mode_q;

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			latch_q <= {5{`MPP_RST_LATCH}};
			dir_q <= {5{`MPP_RST_DIR}};
			ctrl_q <= {5{`MPP_RST_CTRL}};
		end else if (wr_ok && !slot[3] && reg_addr[3] == 1'b0) begin
			if (reg_addr[7:4] == `MPP_KIND_DATA) begin
				latch_q[slot[2:0]] <= reg_wdata & VALID_MASK[slot[2:0]];
			end else if (reg_addr[7:4] == `MPP_KIND_DIR) begin
				// bits that cannot drive stay input whatever is written
				dir_q[slot[2:0]] <= reg_wdata | ~OUT_CAP[slot[2:0]];
			end else if (reg_addr[7:4] == `MPP_KIND_CTRL) begin
				ctrl_q[slot[2:0]] <= reg_wdata & VALID_MASK[slot[2:0]];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			pullup_option_low_q <= `MPP_RST_PULLUP_OPTION_LOW;
			rise_q <= `MPP_RST_EDGE;
			fall_q <= `MPP_RST_EDGE;
		end else if (wr_ok) begin
			if (reg_addr == `MPP_ADDR_PULLUP_OPTION_LOW) begin
				pullup_option_low_q <= reg_wdata & 8'h8f;
			end else if (reg_addr == `MPP_ADDR_EDGE_RISE) begin
				rise_q <= reg_wdata[5:0];
			end else if (reg_addr == `MPP_ADDR_EDGE_FALL) begin
				fall_q <= reg_wdata[5:0];
			end
		end
	end

	// sticky edge flags, write one to clear; a new edge beats the clear
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			stat_q <= `MPP_RST_EDGE;
		end else if (wr_ok && reg_addr == `MPP_ADDR_EDGE_STAT) begin
			stat_q <= (stat_q & ~reg_wdata[5:0]) | edge_pulse;
		end else begin
			stat_q <= stat_q | edge_pulse;
		end
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (!slot[3] && reg_addr[3] == 1'b0 && reg_addr[7:4] == `MPP_KIND_DATA) begin
			// inputs read the pin, outputs read their latch
			reg_rdata <= ((pin_s[slot[2:0]] & dir_q[slot[2:0]]) |
				(latch_q[slot[2:0]] & ~dir_q[slot[2:0]])) & VALID_MASK[slot[2:0]];
		end else if (!slot[3] && reg_addr[3] == 1'b0 && reg_addr[7:4] == `MPP_KIND_DIR) begin
			reg_rdata <= dir_q[slot[2:0]] & VALID_MASK[slot[2:0]];
		end else if (!slot[3] && reg_addr[3] == 1'b0 && reg_addr[7:4] == `MPP_KIND_CTRL) begin
			reg_rdata <= ctrl_q[slot[2:0]];
		end else if (reg_addr == `MPP_ADDR_PULLUP_OPTION_LOW) begin
			reg_rdata <= pullup_option_low_q;
		end else if (reg_addr == `MPP_ADDR_EDGE_RISE) begin
			reg_rdata <= {2'h0, rise_q};
		end else if (reg_addr == `MPP_ADDR_EDGE_FALL) begin
			reg_rdata <= {2'h0, fall_q};
		end else if (reg_addr == `MPP_ADDR_EDGE_STAT) begin
			reg_rdata <= {2'h0, stat_q};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// external interrupt edges
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_edge
			mpp_edge u_edge (
				.core_clk(core_clk),
				.sys_rst(int_rst),
				.sig(pin_s[0][gi] & ctrl_q[0][gi]),
				.rise_en(rise_q[gi]),
				.fall_en(fall_q[gi]),
				.pulse(edge_pulse[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// pins toward the board
	mpp_pkg::mpp_port_vec_t pout;
	mpp_pkg::mpp_port_vec_t out_d;
	mpp_pkg::mpp_port_vec_t oe_d;
	mpp_pkg::mpp_port_vec_t pu_d;
	mpp_pkg::mpp_port_vec_t out_q;
	mpp_pkg::mpp_port_vec_t oe_q;
	mpp_pkg::mpp_port_vec_t pu_q;

	// peripheral drive per port; the latch must hold one to let it through
	assign pout[0] = 8'h00;
	assign pout[1] = 8'h00;
	assign pout[2] = {5'h00, periph_in.ser0_clock_out, periph_in.ser0_data_out,
		periph_in.serbus_line_a_out};
	assign pout[3] = {1'b0, periph_in.buzzer_out_pin, periph_in.clock_out_pin, 2'h0,
		periph_in.timer_outputs};
	assign pout[4] = {5'h00, periph_in.ser2_clock_out, periph_in.ser2_data_out, 1'b0};

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			for (int b = 0; b < 8; b++) begin
				out_d[i][b] = ctrl_q[i][b] ? (latch_q[i][b] & pout[i][b]) : latch_q[i][b];
				oe_d[i][b] = ~dir_q[i][b] & OUT_CAP[i][b];
				pu_d[i][b] = dir_q[i][b] & pullup_option_low_q[PORT_NUM[i]] & VALID_MASK[i][b];
				// port 0 peripheral functions are all inputs
				if (i == 0 && ctrl_q[i][b]) begin
					oe_d[i][b] = 1'b0;
				end
				if (i == 1 && ctrl_q[i][b]) begin
					oe_d[i][b] = 1'b0;
					pu_d[i][b] = 1'b0;
				end
				if (prom_mode_q) begin
					oe_d[i][b] = 1'b0;
					pu_d[i][b] = 1'b0;
				end
			end
		end
		// serial bus lines are open drain: they only ever pull low
		if (ctrl_q[2][0] && periph_in.serbus_enable && !prom_mode_q) begin
			out_d[2][0] = 1'b0;
			oe_d[2][0] = ~dir_q[2][0] & ~(latch_q[2][0] & periph_in.serbus_line_a_out);
		end
		if (ctrl_q[2][1] && periph_in.serbus_enable && !prom_mode_q) begin
			out_d[2][1] = 1'b0;
			oe_d[2][1] = ~dir_q[2][1] & ~(latch_q[2][1] & periph_in.serbus_line_b_out);
		end
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			out_q <= '0;
			oe_q <= '0;
			pu_q <= '0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
			pu_q <= pu_d;
		end
	end

	assign p0_pin_out = out_q[0];
	assign p0_pin_oe = oe_q[0];
	assign p0_pullup_en = pu_q[0];
	assign p1_pin_out = out_q[1];
	assign p1_pin_oe = oe_q[1];
	assign p1_pullup_en = pu_q[1];
	assign p2_pin_out = out_q[2][2:0];
	assign p2_pin_oe = oe_q[2][2:0];
	assign p2_pullup_en = pu_q[2][2:0];
	assign p3_pin_out = out_q[3];
	assign p3_pin_oe = oe_q[3];
	assign p3_pullup_en = pu_q[3];
	assign p7_pin_out = out_q[4][2:0];
	assign p7_pin_oe = oe_q[4][2:0];
	assign p7_pullup_en = pu_q[4][2:0];

	////////////////////////////////////////////////////////////////////////////
	// pins toward the peripherals, gated by their control bit
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			periph_out <= '0;
		end else begin
			periph_out.ext_irq_req <= edge_pulse;
			periph_out.tmr16_capture_pulse <= edge_pulse[0] | edge_pulse[1];
			periph_out.tmr16_count_in <= pin_s[0][0] & ctrl_q[0][0];
			periph_out.tmr16_capture_trigger <= pin_s[0][1] & ctrl_q[0][1];
			periph_out.sub_crystal_in <= pin_s[0][7] & ctrl_q[0][7];
			periph_out.analog_inputs <= pin_s[1] & ctrl_q[1];
			periph_out.ser0_data_in <= pin_s[2][0] & ctrl_q[2][0];
			periph_out.serbus_line_a_in <= pin_s[2][0] & ctrl_q[2][0];
			periph_out.serbus_line_b_in <= pin_s[2][1] & ctrl_q[2][1];
			periph_out.ser0_clock_in <= pin_s[2][2] & ctrl_q[2][2];
			periph_out.tmr8a_count_in <= pin_s[3][3] & ctrl_q[3][3];
			periph_out.tmr8b_count_in <= pin_s[3][4] & ctrl_q[3][4];
			periph_out.ser2_data_in <= pin_s[4][0] & ctrl_q[4][0];
			periph_out.ser2_clock_in <= pin_s[4][2] & ctrl_q[4][2];
		end
	end
endmodule : mpp_top

// ---- include/mpp_cfg.svh ----
// register offsets, field masks and reset values of the multiplexed port pin block
`ifndef MPP_CFG_SVH
`define MPP_CFG_SVH

// address kinds in addr[7:4]; addr[2:0] carries the port number 0, 1, 2, 3 or 7
`define MPP_KIND_DATA 4'h0
`define MPP_KIND_DIR 4'h2
`define MPP_KIND_CTRL 4'h4
`define MPP_ADDR_PULLUP_OPTION_LOW 8'h30
`define MPP_ADDR_EDGE_RISE 8'h50
`define MPP_ADDR_EDGE_FALL 8'h51
`define MPP_ADDR_EDGE_STAT 8'h52

// implemented bits of each port
`define MPP_MASK_P0 8'hbf
`define MPP_MASK_P1 8'hff
`define MPP_MASK_P2 8'h07
`define MPP_MASK_P3 8'hff
`define MPP_MASK_P7 8'h07
// port 0 bits that may drive in port mode
`define MPP_P0_OUT_MASK 8'h3e

`define MPP_RST_LATCH 8'h00
`define MPP_RST_DIR 8'hff
`define MPP_RST_CTRL 8'h00
`define MPP_RST_PULLUP_OPTION_LOW 8'h00
`define MPP_RST_EDGE 6'h00

`endif

// ---- include/mpp_pkg.sv ----
// types shared by the multiplexed port pin block
package mpp_pkg;

	// index 0..4 stands for ports 0, 1, 2, 3, 7
	typedef logic [4:0][7:0] mpp_port_vec_t;

	// signals that peripherals drive toward the pins
	typedef struct packed {
		logic [2:0] timer_outputs;
		logic clock_out_pin;
		logic buzzer_out_pin;
		logic ser0_data_out;
		logic ser0_clock_out;
		logic serbus_enable;
		logic serbus_line_a_out;
		logic serbus_line_b_out;
		logic ser2_data_out;
		logic ser2_clock_out;
	} mpp_periph_in_t;

	// signals that the pins deliver to peripherals
	typedef struct packed {
		logic [5:0] ext_irq_req;
		logic tmr16_capture_pulse;
		logic tmr16_count_in;
		logic tmr16_capture_trigger;
		logic tmr8a_count_in;
		logic tmr8b_count_in;
		logic sub_crystal_in;
		logic ser0_data_in;
		logic ser0_clock_in;
		logic serbus_line_a_in;
		logic serbus_line_b_in;
		logic ser2_data_in;
		logic ser2_clock_in;
		logic [7:0] analog_inputs;
	} mpp_periph_out_t;

	// programming-mode request toward the prom array
	typedef struct packed {
		logic active;
		logic [16:0] addr;
		logic [7:0] wdata;
		logic write_pulse;
		logic read_active;
	} mpp_prom_req_t;

endpackage : mpp_pkg

// ---- design/mpp_sync.sv ----
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module mpp_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : mpp_sync

// ---- design/mpp_edge.sv ----
// valid-edge detector for one external interrupt input
`timescale 1ns/1ps
module mpp_edge (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sig,
	input wire logic rise_en,
	input wire logic fall_en,
	output logic pulse
);
	logic prev_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sig;
		end
	end

	assign pulse = (sig & ~prev_q & rise_en) | (~sig & prev_q & fall_en);
endmodule : mpp_edge

// ---- tb/mpp_checker_assertions.sv ----
// assertions on the ports of the multiplexed port pin block
`timescale 1ns/1ps
module mpp_checker (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ext_reset_n,
	input wire logic vpp_high_in,
	input wire logic [7:0] p0_pin_oe,
	input wire logic [7:0] p0_pullup_en,
	input wire logic [7:0] p1_pin_oe,
	input wire logic [7:0] p1_pullup_en,
	input wire logic [7:0] p3_pin_oe,
	input wire logic [7:0] p3_pullup_en,
	input wire logic prom_data_oe,
	input wire mpp_pkg::mpp_prom_req_t prom_req,
	input wire logic prom_mode,
	input wire mpp_pkg::mpp_periph_out_t periph_out,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// sync plus register makes entry take three edges; five leaves margin
	sequence s_prog_req;
		(vpp_high_in || !ext_reset_n) [*5];
	endsequence
	sequence s_prog_held;
		prom_mode [*2];
	endsequence
	p0_input_only_a: assert property ((p0_pin_oe & 8'hc1) == 8'h00)
		else $error("port 0 drives an input-only bit");
	pull_on_input_a: assert property (((p0_pin_oe & p0_pullup_en) |
		(p1_pin_oe & p1_pullup_en) | (p3_pin_oe & p3_pullup_en)) == 8'h00)
		else $error("pull-up on a driven pin");
	analog_no_pull_a: assert property ((periph_out.analog_inputs & p1_pullup_en) == 8'h00)
		else $error("pull-up left on an analog pin");
	reset_quiet_a: assert property (disable iff (1'h0) sys_rst |=>
		(p0_pin_oe | p1_pin_oe | p3_pin_oe | p1_pullup_en) == 8'h00 && periph_out == '0)
		else $error("outputs active after reset");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	capture_tied_a: assert property (periph_out.tmr16_capture_pulse |->
		periph_out.ext_irq_req[1:0] != 2'h0)
		else $error("capture without edge on input 0 or 1");
	prom_entry_a: assert property (s_prog_req |-> prom_mode)
		else $error("programming mode not entered");
	prom_quiet_a: assert property (s_prog_held |-> (p0_pin_oe | p1_pin_oe | p3_pin_oe) == 8'h00)
		else $error("port pin driven in programming mode");
	prom_oe_a: assert property (prom_data_oe |-> $past(prom_mode))
		else $error("data bus driven outside programming mode");
	write_pulse_a: assert property (prom_req.write_pulse |=> !prom_req.write_pulse)
		else $error("program pulse longer than one cycle");
endmodule : mpp_checker
bind mpp_top mpp_checker i_mpp_checker (.*);

// ---- tb/mpp_board.sv ----
// board side of the port pins: device drive wins, else the board level
`timescale 1ns/1ps
module mpp_board #(
	parameter int W = 30
) (
	input wire logic [W-1:0] dev_out,
	input wire logic [W-1:0] dev_oe,
	input wire logic [W-1:0] ext,
	output logic [W-1:0] pin
);
	// the board always holds its lines, so pull-ups never decide a level here
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin[i] = dev_oe[i] ? dev_out[i] : ext[i];
		end
	end
endmodule : mpp_board

// ---- tb/mpp_top_tb.sv ----
// self-checking bench of the multiplexed port pin block
`timescale 1ns/1ps
module mpp_top_tb;
	logic core_clk = 1'h0, sys_rst = 1'h1, ext_reset_n = 1'h1, vpp_high_in = 1'h0;
	logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p0_pullup_en, p1_pin_in, p1_pin_out;
	logic [7:0] p1_pin_oe, p1_pullup_en, p3_pin_in, p3_pin_out, p3_pin_oe, p3_pullup_en;
	logic [2:0] p2_pin_in, p2_pin_out, p2_pin_oe, p2_pullup_en;
	logic [2:0] p7_pin_in, p7_pin_out, p7_pin_oe, p7_pullup_en;
	logic [16:0] prom_addr_in = 17'h0;
	logic [7:0] prom_data_in = 8'h00, prom_rdata = 8'h00, prom_data_out, reg_rdata, wd_seen;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, f;
	logic prom_enable_n = 1'h1, prom_read_n = 1'h1, program_inhibit_in = 1'h1;
	logic reg_wr = 1'h0, reg_rd = 1'h0, prom_data_oe, prom_mode;
	mpp_pkg::mpp_prom_req_t prom_req;
	mpp_pkg::mpp_periph_in_t periph_in = '0;
	mpp_pkg::mpp_periph_out_t periph_out;
	mpp_pkg::mpp_port_vec_t oe_v, pu_v, out_v;
	logic [29:0] ext = 30'h0, pins;
	logic [7:0] mdl [256];
	logic [7:0] alist [16] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27, 8'h40, 8'h41, 8'h42,
		8'h43, 8'h47, 8'h30, 8'h50, 8'h51, 8'h52, 8'h24, 8'hff};
	integer irq_cnt [6], exp_irq [6], cap_cnt, exp_cap, wp_cnt;
	int n_mismatch = 0, total_checks = 0, cyc = 0, k;
	bit prom_on = 1'h0;
	mpp_top i_mpp_top (.*);
	mpp_board i_mpp_board (.dev_out({p7_pin_out, p3_pin_out, p2_pin_out, p1_pin_out, p0_pin_out}),
		.dev_oe({p7_pin_oe, p3_pin_oe, p2_pin_oe, p1_pin_oe, p0_pin_oe}), .ext(ext), .pin(pins));
	assign {p7_pin_in, p3_pin_in, p2_pin_in, p1_pin_in, p0_pin_in} = pins;
	assign oe_v = {8'(p7_pin_oe), p3_pin_oe, 8'(p2_pin_oe), p1_pin_oe, p0_pin_oe};
	assign pu_v = {8'(p7_pullup_en), p3_pullup_en, 8'(p2_pullup_en), p1_pullup_en, p0_pullup_en};
	assign out_v = {8'(p7_pin_out), p3_pin_out, 8'(p2_pin_out), p1_pin_out, p0_pin_out};
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	function automatic logic [7:0] pn(input int i);
		return (i == 4) ? 8'h07 : 8'(i);
	endfunction : pn
	function automatic logic [7:0] msk(input logic [2:0] n);
		case (n)
			3'h0: return 8'hbf;
			3'h1, 3'h3: return 8'hff;
			3'h2, 3'h7: return 8'h07;
			default: return 8'h00;
		endcase
	endfunction : msk
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic mdl_wr(input logic [7:0] a, input logic [7:0] d);
		case (a[7:4])
			4'h0, 4'h4: mdl[a] = d & msk(a[2:0]);
			4'h2: mdl[a] = (d | ((a[2:0] == 3'h0) ? 8'hc1 : 8'h00)) & msk(a[2:0]);
			4'h3: if (a == 8'h30) mdl[a] = d & 8'h8f;
			4'h5: if (a < 8'h52) mdl[a] = d & 8'h3f; else if (a == 8'h52) mdl[a] &= ~d;
			default: ;
		endcase
	endtask : mdl_wr
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		@(posedge core_clk);
		if (!prom_on) mdl_wr(a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1;
		chk($sformatf("reg %h", a), reg_rdata, mdl[a]);
		@(posedge core_clk);
	endtask : rd
	task automatic pins_chk;
		logic [7:0] n, d, c, o, u;
		for (int i = 0; i < 5; i++) begin
			n = pn(i);
			d = mdl[8'h20 | n];
			c = mdl[8'h40 | n];
			o = ~d & msk(n[2:0]) & ((i == 0) ? 8'h3e : 8'hff) & ((i < 2) ? ~c : 8'hff);
			u = d & msk(n[2:0]) & {8{mdl[8'h30][n[2:0]]}} & ((i == 1) ? ~c : 8'hff);
			if (i == 2 && periph_in.serbus_enable) begin
				o[1:0] = o[1:0] & ~(c[1:0] & mdl[8'h02][1:0] &
					{periph_in.serbus_line_b_out, periph_in.serbus_line_a_out});
				chk("serbus out", out_v[2][1:0] & c[1:0], 2'h0);
			end
			chk("oe", oe_v[i], o);
			chk("pullup", pu_v[i] & msk(n[2:0]), u);
			chk("out", out_v[i] & o & ~c, mdl[n] & o & ~c);
		end
	endtask : pins_chk
	// direction and latch go in before the control bit, as serial use needs
	task automatic setup(input bit ctl);
		for (int i = 0; i < 5; i++) begin
			wr(8'h20 | pn(i), 8'($urandom));
			wr(pn(i), 8'($urandom));
			wr(8'h40 | pn(i), ctl ? 8'($urandom) : 8'h00);
		end
		wr(8'h30, 8'($urandom));
		ext <= 30'($urandom);
		periph_in <= mpp_pkg::mpp_periph_in_t'(12'($urandom));
		repeat (4) @(posedge core_clk);
		pins_chk();
		foreach (alist[j]) rd(alist[j]);
	endtask : setup
	////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
		for (int j = 0; j < 6; j++) irq_cnt[j] += periph_out.ext_irq_req[j];
		cap_cnt += periph_out.tmr16_capture_pulse;
		wp_cnt += prom_req.write_pulse;
		if (prom_req.write_pulse) wd_seen = prom_req.wdata;
	end
	initial begin
		void'($urandom(44));
		foreach (mdl[a]) mdl[a] = (a / 16 == 2) ? msk(3'(a)) : 8'h00;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'h0;
		pins_chk();
		foreach (alist[j]) rd(alist[j]);
		$display("test reset done");
		repeat (20) setup(1'h0);
		$display("test port mode done");
		repeat (20) begin
			setup(1'h1);
			f = mdl[8'h43] & mdl[8'h03] & 8'h67;
			chk("p3 func", p3_pin_out & f, {1'h0, periph_in.buzzer_out_pin,
				periph_in.clock_out_pin, 2'h0, periph_in.timer_outputs} & f);
			chk("analog", periph_out.analog_inputs, p1_pin_in & mdl[8'h41]);
			chk("tmr8", {periph_out.tmr8b_count_in, periph_out.tmr8a_count_in},
				p3_pin_in[4:3] & mdl[8'h43][4:3]);
			chk("tmr16", {periph_out.tmr16_capture_trigger, periph_out.tmr16_count_in},
				p0_pin_in[1:0] & mdl[8'h40][1:0]);
			chk("serial in", {periph_out.ser2_clock_in, periph_out.ser2_data_in,
				periph_out.ser0_clock_in, periph_out.serbus_line_b_in, periph_out.serbus_line_a_in,
				periph_out.ser0_data_in, periph_out.sub_crystal_in},
				{p7_pin_in[2], p7_pin_in[0], p2_pin_in[2], p2_pin_in[1], p2_pin_in[0],
				p2_pin_in[0], p0_pin_in[7]} & {mdl[8'h47][2], mdl[8'h47][0], mdl[8'h42][2],
				mdl[8'h42][1], mdl[8'h42][0], mdl[8'h42][0], mdl[8'h40][7]});
		end
		$display("test control mode done");
		ext[5:0] <= 6'h00;
		wr(8'h20, 8'hff);
		wr(8'h40, 8'h3f);
		for (int m = 1; m < 4; m++) begin
			wr(8'h50, m[0] ? 8'h3f : 8'h00);
			wr(8'h51, m[1] ? 8'h3f : 8'h00);
			wr(8'h52, 8'h3f);
			cap_cnt = 0;
			exp_cap = 0;
			foreach (irq_cnt[j]) begin
				irq_cnt[j] = 0;
				exp_irq[j] = 0;
			end
			repeat (24) begin
				k = $urandom_range(5);
				if (ext[k] ? m[1] : m[0]) begin
					exp_irq[k]++;
					mdl[8'h52][k] = 1'h1;
					if (k < 2) exp_cap++;
				end
				ext[k] <= ~ext[k];
				repeat (7) @(posedge core_clk);
			end
			foreach (irq_cnt[j]) chk("irq count", irq_cnt[j], exp_irq[j]);
			chk("capture count", cap_cnt, exp_cap);
			rd(8'h52);
			wr(8'h52, 8'h3f);
			rd(8'h52);
		end
		$display("test edge detect done");
		vpp_high_in <= 1'h1;
		prom_addr_in <= 17'($urandom);
		prom_rdata <= 8'($urandom);
		prom_data_in <= 8'($urandom);
		prom_enable_n <= 1'h0;
		prom_read_n <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk("prom mode", prom_mode, 1'h1);
		chk("prom oe", prom_data_oe, 1'h1);
		chk("prom data", prom_data_out, prom_rdata);
		chk("prom addr", prom_req.addr, prom_addr_in);
		chk("prom req", {prom_req.active, prom_req.read_active}, 2'h3);
		chk("pins off", {p0_pin_oe, p1_pin_oe, p3_pin_oe, p1_pullup_en}, 32'h0);
		prom_on = 1'h1;
		wr(8'h21, ~mdl[8'h21]);
		prom_read_n <= 1'h1;
		wp_cnt = 0;
		repeat (4) @(posedge core_clk);
		program_inhibit_in <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk("write pulses", wp_cnt, 1);
		chk("write data", wd_seen, prom_data_in);
		{vpp_high_in, prom_enable_n, program_inhibit_in} <= 3'h3;
		repeat (6) @(posedge core_clk);
		prom_on = 1'h0;
		rd(8'h21);
		ext_reset_n <= 1'h0;
		repeat (6) @(posedge core_clk);
		chk("reset pin mode", prom_mode, 1'h1);
		ext_reset_n <= 1'h1;
		repeat (6) @(posedge core_clk);
		foreach (mdl[a]) mdl[a] = (a / 16 == 2) ? msk(3'(a)) : 8'h00;
		pins_chk();
		foreach (alist[j]) rd(alist[j]);
		$display("test programming mode done");
		conclude();
	end
endmodule : mpp_top_tb
